// ---- core/slfs_map.svh ----
// Offsets, field positions, reset values and timing figures of the link supervisor
`ifndef SLFS_MAP_SVH
`define SLFS_MAP_SVH
// ==========================================================
// Timing
`define SLFS_CLK_MHZ 100
`define SLFS_TICK_MS 10
`define SLFS_PROC_NS 100
`define SLFS_ERRT_UNIT_MS 100
`define SLFS_NRT_UNIT_MS 1000
`define SLFS_DLY_UNIT_MS 10
// ==========================================================
// Device register offsets
`define SLFS_OFS_SET 12'h000
`define SLFS_OFS_TIM 12'h004
`define SLFS_OFS_CTL 12'h008
`define SLFS_OFS_STAT 12'h00c
`define SLFS_OFS_ISTAT 12'h010
`define SLFS_OFS_IMASK 12'h014
// Host register offsets
`define SLFS_OFS_HCTL 12'h000
`define SLFS_OFS_HCFG 12'h004
`define SLFS_OFS_HSTAT 12'h008
`define SLFS_OFS_HISTAT 12'h00c
`define SLFS_OFS_HIMASK 12'h010
// ==========================================================
// Settings word fields
`define SLFS_F_STATION_LSB 0
`define SLFS_F_STATION_W 8
`define SLFS_F_MODE_LSB 8
`define SLFS_F_MODE_W 2
`define SLFS_F_RATE_LSB 10
`define SLFS_F_RATE_W 3
`define SLFS_F_PARITY_LSB 13
`define SLFS_F_PARITY_W 2
`define SLFS_F_DLEN_LSB 15
`define SLFS_F_STOP_LSB 16
`define SLFS_F_PROTO_LSB 17
`define SLFS_F_PROTO_W 2
`define SLFS_F_LMODE_LSB 19
`define SLFS_F_LMODE_W 4
`define SLFS_F_BMODE_LSB 23
`define SLFS_F_BMODE_W 2
// Timer word fields
`define SLFS_F_ERRT_LSB 0
`define SLFS_F_ERRT_W 10
`define SLFS_F_NRT_LSB 10
`define SLFS_F_NRT_W 6
`define SLFS_F_DLY_LSB 16
`define SLFS_F_DLY_W 7
// Host control register fields
`define SLFS_F_HSEND 0
`define SLFS_F_HABORT 1
`define SLFS_F_HSTN_LSB 8
// ==========================================================
// Reset values and writable masks
`define SLFS_SET_RST 32'h0000_0c01
`define SLFS_SET_MASK 32'h01ff_ffff
`define SLFS_TIM_RST 32'h0001_0014
`define SLFS_TIM_MASK 32'h007f_ffff
`define SLFS_HCFG_RST 32'h0000_0004
`define SLFS_HCFG_MASK 32'h0000_007f
`define SLFS_HSTN_RST 8'h01
// Codes with a fixed meaning
`define SLFS_LMODE_NET 4'h8
`define SLFS_BMODE_FOLLOW 2'h0
`endif

// ---- core/slfs_pkg.sv ----
// Types and shared arithmetic of the link supervisor
package slfs_pkg;
  // ==========================================================
  // Error handling modes
  typedef enum logic [1:0] {
    EM_TRIP_NOW = 2'h0,
    EM_TRIP_LATE = 2'h1,
    EM_RECOVER = 2'h2,
    EM_RUN_ON = 2'h3
  } slfs_err_mode_type;

  // Fault supervisor states
  typedef enum logic [3:0] {
    FLT_IDLE = 4'h1,
    FLT_WAIT = 4'h2,
    FLT_RECOVER = 4'h4,
    FLT_TRIP = 4'h8
  } slfs_fault_type;

  // Setting value times a per-unit count, cut to 32 bits
  function automatic logic [31:0] slfs_scale(input logic [15:0] val, input int unsigned per);
    slfs_scale = 32'(val * per);
  endfunction
endpackage

// ---- core/slfs_link_if.sv ----
// Frame level serial link between the card end and the inverter end
interface slfs_link_if;
  logic req_valid;
  logic req_abort;
  logic [7:0] req_station;
  logic [2:0] req_rate;
  logic [1:0] req_parity;
  logic [1:0] req_proto;
  logic rsp_valid;
  logic [7:0] rsp_station;

  modport dev (
    input req_valid, req_abort, req_station, req_rate, req_parity, req_proto,
    output rsp_valid, rsp_station
  );
  modport host (
    output req_valid, req_abort, req_station, req_rate, req_parity, req_proto,
    input rsp_valid, rsp_station
  );
endinterface

// ---- core/slfs_dev.sv ----
// Inverter end: link settings, fault supervision, no-response timer and response delay
//
// Behaviour
// - Station address setting must be one.
// - No link command source: ignore all errors.
// - Mode 0 trips at once; 1 after timer.
// - Mode 2 recovers for timer, then trips.
// - Mode 3 never trips on link errors.
// - Error timer matters in mode 2; 60s advised.
// - No-response time acts only in mode 2.
// - Timeout raised within no-response time.
// - Requests within grace clear; else trip.
// - Respond after processing plus programmed delay.
// - Rate code 4 is 38.4kbaud, both ends; the inverter end resets to code 3.
// - Parity code 0, no parity bit.
// - Protocol code 0, Modbus RTU framing.
// - Data length and stop bits ignored.
// - Truncated frame from card is a link error.
// - Link mode 8 takes run and frequency.
// - Bus link mode 0 follows link mode.
`include "slfs_map.svh"

module slfs_dev #(
  parameter int unsigned TICK_CYCLES = `SLFS_TICK_MS * `SLFS_CLK_MHZ * 1000,
  parameter int unsigned PROC_CYCLES = (`SLFS_PROC_NS * `SLFS_CLK_MHZ + 999) / 1000
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  slfs_link_if.dev link,
  output logic trip_o,
  output logic irq_o
);
  localparam int unsigned ERRT_TICKS = `SLFS_ERRT_UNIT_MS / `SLFS_TICK_MS;
  localparam int unsigned NRT_TICKS = `SLFS_NRT_UNIT_MS / `SLFS_TICK_MS;
  localparam int unsigned DLY_TICKS = `SLFS_DLY_UNIT_MS / `SLFS_TICK_MS;

  logic [31:0] set_r;
  logic [31:0] tim_r;
  logic [2:0] istat_r;
  logic [2:0] imask_r;
  logic [31:0] prdata_r;
  slfs_pkg::slfs_fault_type state_r;
  slfs_pkg::slfs_fault_type state_nxt;
  logic [31:0] ft_cnt_r;
  logic [31:0] nr_cnt_r;
  logic nr_armed_r;
  logic [31:0] tick_cnt_r;
  logic tick_r;
  logic rsp_busy_r;
  logic [31:0] rsp_cnt_r;
  logic rsp_valid_r;
  logic [7:0] rsp_station_r;

  // ==========================================================
  // Setting fields
  logic [7:0] station_address_setting;
  logic [1:0] link_error_mode;
  logic [2:0] link_rate_setting;
  logic [1:0] parity_setting;
  logic [1:0] protocol_select;
  logic [3:0] link_mode_select;
  logic [1:0] bus_link_mode_select;
  logic [9:0] link_error_timer;
  logic [5:0] no_response_time;
  logic [6:0] response_delay_setting;
  assign station_address_setting = set_r[`SLFS_F_STATION_LSB +: `SLFS_F_STATION_W];
  assign link_error_mode = set_r[`SLFS_F_MODE_LSB +: `SLFS_F_MODE_W];
  assign link_rate_setting = set_r[`SLFS_F_RATE_LSB +: `SLFS_F_RATE_W];
  assign parity_setting = set_r[`SLFS_F_PARITY_LSB +: `SLFS_F_PARITY_W];
  assign protocol_select = set_r[`SLFS_F_PROTO_LSB +: `SLFS_F_PROTO_W];
  assign link_mode_select = set_r[`SLFS_F_LMODE_LSB +: `SLFS_F_LMODE_W];
  assign bus_link_mode_select = set_r[`SLFS_F_BMODE_LSB +: `SLFS_F_BMODE_W];
  assign link_error_timer = tim_r[`SLFS_F_ERRT_LSB +: `SLFS_F_ERRT_W];
  assign no_response_time = tim_r[`SLFS_F_NRT_LSB +: `SLFS_F_NRT_W];
  assign response_delay_setting = tim_r[`SLFS_F_DLY_LSB +: `SLFS_F_DLY_W];

  // ==========================================================
  // APB decode
  logic wr_en;
  logic rd_setup;
  logic hit;
  logic wr_set;
  logic wr_tim;
  logic wr_ctl;
  logic wr_istat;
  logic wr_imask;
  logic trip_clear;
  logic [31:0] rd_mux;
  assign wr_en = psel_i & penable_i & pwrite_i;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
  assign hit = (paddr_i == `SLFS_OFS_SET) | (paddr_i == `SLFS_OFS_TIM) |
               (paddr_i == `SLFS_OFS_CTL) | (paddr_i == `SLFS_OFS_STAT) |
               (paddr_i == `SLFS_OFS_ISTAT) | (paddr_i == `SLFS_OFS_IMASK);
  assign wr_set = wr_en & (paddr_i == `SLFS_OFS_SET);
  assign wr_tim = wr_en & (paddr_i == `SLFS_OFS_TIM);
  assign wr_ctl = wr_en & (paddr_i == `SLFS_OFS_CTL);
  assign wr_istat = wr_en & (paddr_i == `SLFS_OFS_ISTAT);
  assign wr_imask = wr_en & (paddr_i == `SLFS_OFS_IMASK);
  assign trip_clear = wr_ctl & pwdata_i[0];
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit;
  assign prdata_o = prdata_r;

  // Control source and link qualification
  logic run_from_link;
  logic freq_from_link;
  logic ignoring;
  logic cfg_ok;
  logic good_req;
  logic bad_frame;
  logic trunc_frame;
  assign run_from_link = (bus_link_mode_select == `SLFS_BMODE_FOLLOW) &
                         ((link_mode_select == `SLFS_LMODE_NET) | link_mode_select[1]);
  assign freq_from_link = (bus_link_mode_select == `SLFS_BMODE_FOLLOW) &
                          ((link_mode_select == `SLFS_LMODE_NET) | link_mode_select[0]);
  assign ignoring = ~(run_from_link | freq_from_link);
  // Data length and stop bits take no part in the match
  assign cfg_ok = (link.req_rate == link_rate_setting) &
                  (link.req_parity == parity_setting) &
                  (link.req_proto == protocol_select);
  assign good_req = link.req_valid & cfg_ok &
                    (link.req_station == station_address_setting);
  assign bad_frame = link.req_valid & ~cfg_ok;
  assign trunc_frame = link.req_abort;

  // Timer limits: error and no-response in ticks, response in clock cycles
  logic [31:0] errt_lim;
  logic [31:0] nrt_lim;
  logic [31:0] rsp_lim;
  logic nr_active;
  logic nr_expire;
  logic err_evt;
  logic ft_done;
  assign errt_lim = slfs_pkg::slfs_scale({6'h00, link_error_timer}, ERRT_TICKS);
  assign nrt_lim = slfs_pkg::slfs_scale({10'h000, no_response_time}, NRT_TICKS);
  assign rsp_lim = slfs_pkg::slfs_scale({9'h000, response_delay_setting},
                                        DLY_TICKS * TICK_CYCLES) + PROC_CYCLES;
  assign nr_active = (link_error_mode == slfs_pkg::EM_RECOVER) &
                     (no_response_time != 6'h00) & ~ignoring & nr_armed_r;
  assign nr_expire = nr_active & (nr_cnt_r >= nrt_lim);
  assign err_evt = (bad_frame | trunc_frame | nr_expire) & ~ignoring;
  assign ft_done = ft_cnt_r >= errt_lim;
  assign rd_mux = (paddr_i == `SLFS_OFS_SET) ? set_r :
                  (paddr_i == `SLFS_OFS_TIM) ? tim_r :
                  (paddr_i == `SLFS_OFS_STAT) ? {26'h0, rsp_busy_r, ignoring, state_r} :
                  (paddr_i == `SLFS_OFS_ISTAT) ? {29'h0, istat_r} :
                  (paddr_i == `SLFS_OFS_IMASK) ? {29'h0, imask_r} : 32'h0000_0000;

  // ==========================================================
  // Fault supervisor next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      slfs_pkg::FLT_IDLE: begin
        if (err_evt) begin
          unique case (link_error_mode)
            slfs_pkg::EM_TRIP_NOW: state_nxt = slfs_pkg::FLT_TRIP;
            slfs_pkg::EM_TRIP_LATE: state_nxt = slfs_pkg::FLT_WAIT;
            slfs_pkg::EM_RECOVER: state_nxt = slfs_pkg::FLT_RECOVER;
            slfs_pkg::EM_RUN_ON: state_nxt = slfs_pkg::FLT_IDLE;
          endcase
        end
      end
      slfs_pkg::FLT_WAIT: begin
        if (ignoring || link_error_mode == slfs_pkg::EM_RUN_ON) begin
          state_nxt = slfs_pkg::FLT_IDLE;
        end else if (ft_done) begin
          state_nxt = slfs_pkg::FLT_TRIP;
        end
      end
      slfs_pkg::FLT_RECOVER: begin
        if (ignoring || link_error_mode == slfs_pkg::EM_RUN_ON) begin
          state_nxt = slfs_pkg::FLT_IDLE;
        end else if (good_req) begin
          state_nxt = slfs_pkg::FLT_IDLE;
        end else if (ft_done) begin
          state_nxt = slfs_pkg::FLT_TRIP;
        end
      end
      slfs_pkg::FLT_TRIP: begin
        if (trip_clear) begin
          state_nxt = slfs_pkg::FLT_IDLE;
        end
      end
      default: state_nxt = slfs_pkg::FLT_IDLE;
    endcase
  end

  // Registers written by software
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      set_r <= `SLFS_SET_RST;
      tim_r <= `SLFS_TIM_RST;
      imask_r <= 3'h0;
      prdata_r <= 32'h0000_0000;
    end else begin
      if (wr_set) set_r <= pwdata_i & `SLFS_SET_MASK;
      if (wr_tim) tim_r <= pwdata_i & `SLFS_TIM_MASK;
      if (wr_imask) imask_r <= pwdata_i[2:0];
      if (rd_setup) prdata_r <= rd_mux;
    end
  end

  // Sticky events: link error, trip, recovery; set beats clear
  logic [2:0] evt;
  assign evt = {(state_r == slfs_pkg::FLT_RECOVER) & (state_nxt == slfs_pkg::FLT_IDLE) &
                good_req,
                (state_r != slfs_pkg::FLT_TRIP) & (state_nxt == slfs_pkg::FLT_TRIP),
                err_evt};
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      istat_r <= 3'h0;
    end else begin
      istat_r <= (istat_r & ~(wr_istat ? pwdata_i[2:0] : 3'h0)) | evt;
    end
  end
  assign irq_o = |(istat_r & imask_r);

  // Tick prescaler
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == TICK_CYCLES - 1);
      tick_cnt_r <= (tick_cnt_r == TICK_CYCLES - 1) ? 32'h0000_0000 : tick_cnt_r + 32'h1;
    end
  end

  // Fault state and error timer
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_r <= slfs_pkg::FLT_IDLE;
      ft_cnt_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r || state_r == slfs_pkg::FLT_IDLE) begin
        ft_cnt_r <= 32'h0000_0000;
      end else if (tick_r) begin
        ft_cnt_r <= ft_cnt_r + 32'h1;
      end
    end
  end
  assign trip_o = (state_r == slfs_pkg::FLT_TRIP);

  // No-response timer, one timeout per gap
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      nr_cnt_r <= 32'h0000_0000;
      nr_armed_r <= 1'b1;
    end else begin
      if (ignoring || good_req) begin
        nr_cnt_r <= 32'h0000_0000;
        nr_armed_r <= 1'b1;
      end else if (nr_expire) begin
        nr_cnt_r <= 32'h0000_0000;
        nr_armed_r <= 1'b0;
      end else if (nr_active && tick_r) begin
        nr_cnt_r <= nr_cnt_r + 32'h1;
      end
    end
  end

  // Response timing: processing time plus programmed delay
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rsp_busy_r <= 1'b0;
      rsp_cnt_r <= 32'h0000_0000;
      rsp_valid_r <= 1'b0;
      rsp_station_r <= 8'h00;
    end else begin
      rsp_valid_r <= 1'b0;
      if (good_req) begin
        rsp_busy_r <= 1'b1;
        rsp_cnt_r <= 32'h0000_0001;
      end else if (rsp_busy_r) begin
        rsp_cnt_r <= rsp_cnt_r + 32'h1;
        if (rsp_cnt_r >= rsp_lim) begin
          rsp_busy_r <= 1'b0;
          rsp_valid_r <= 1'b1;
          rsp_station_r <= station_address_setting;
        end
      end
    end
  end
  assign link.rsp_valid = rsp_valid_r;
  assign link.rsp_station = rsp_station_r;
endmodule // slfs_dev

// ---- core/slfs_host.sv ----
// Card end: sends request frames on software order and collects responses
`include "slfs_map.svh"

module slfs_host (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  slfs_link_if.host link,
  output logic irq_o
);
  logic [31:0] cfg_r;
  logic [7:0] stn_r;
  logic req_valid_r;
  logic req_abort_r;
  logic awaiting_r;
  logic [7:0] rsp_count_r;
  logic [7:0] last_stn_r;
  logic [1:0] istat_r;
  logic [1:0] imask_r;
  logic [31:0] prdata_r;

  // ==========================================================
  // APB decode
  logic wr_en;
  logic rd_setup;
  logic hit;
  logic wr_ctl;
  logic wr_cfg;
  logic wr_istat;
  logic wr_imask;
  logic send;
  logic abort;
  logic [31:0] rd_mux;
  assign wr_en = psel_i & penable_i & pwrite_i;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
  assign hit = (paddr_i == `SLFS_OFS_HCTL) | (paddr_i == `SLFS_OFS_HCFG) |
               (paddr_i == `SLFS_OFS_HSTAT) | (paddr_i == `SLFS_OFS_HISTAT) |
               (paddr_i == `SLFS_OFS_HIMASK);
  assign wr_ctl = wr_en & (paddr_i == `SLFS_OFS_HCTL);
  assign wr_cfg = wr_en & (paddr_i == `SLFS_OFS_HCFG);
  assign wr_istat = wr_en & (paddr_i == `SLFS_OFS_HISTAT);
  assign wr_imask = wr_en & (paddr_i == `SLFS_OFS_HIMASK);
  assign send = wr_ctl & pwdata_i[`SLFS_F_HSEND];
  assign abort = wr_ctl & pwdata_i[`SLFS_F_HABORT] & ~pwdata_i[`SLFS_F_HSEND];
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit;
  assign prdata_o = prdata_r;
  assign rd_mux = (paddr_i == `SLFS_OFS_HCTL) ? {16'h0, stn_r, 8'h00} :
                  (paddr_i == `SLFS_OFS_HCFG) ? cfg_r :
                  (paddr_i == `SLFS_OFS_HSTAT) ? {8'h0, last_stn_r, rsp_count_r, 7'h0, awaiting_r} :
                  (paddr_i == `SLFS_OFS_HISTAT) ? {30'h0, istat_r} :
                  (paddr_i == `SLFS_OFS_HIMASK) ? {30'h0, imask_r} : 32'h0000_0000;

  // Registers written by software
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      cfg_r <= `SLFS_HCFG_RST;
      stn_r <= `SLFS_HSTN_RST;
      imask_r <= 2'h0;
      prdata_r <= 32'h0000_0000;
    end else begin
      if (wr_cfg) cfg_r <= pwdata_i & `SLFS_HCFG_MASK;
      if (wr_ctl) stn_r <= pwdata_i[`SLFS_F_HSTN_LSB +: 8];
      if (wr_imask) imask_r <= pwdata_i[1:0];
      if (rd_setup) prdata_r <= rd_mux;
    end
  end

  // Request strobes and response bookkeeping
  logic [1:0] evt;
  assign evt = {link.rsp_valid & (link.rsp_station != stn_r), link.rsp_valid};
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      req_valid_r <= 1'b0;
      req_abort_r <= 1'b0;
      awaiting_r <= 1'b0;
      rsp_count_r <= 8'h00;
      last_stn_r <= 8'h00;
      istat_r <= 2'h0;
    end else begin
      req_valid_r <= send;
      req_abort_r <= abort;
      if (send) begin
        awaiting_r <= 1'b1;
      end else if (link.rsp_valid || abort) begin
        awaiting_r <= 1'b0;
      end
      if (link.rsp_valid) begin
        rsp_count_r <= rsp_count_r + 8'h01;
        last_stn_r <= link.rsp_station;
      end
      istat_r <= (istat_r & ~(wr_istat ? pwdata_i[1:0] : 2'h0)) | evt;
    end
  end
  assign irq_o = |(istat_r & imask_r);

  // Frame attributes offered on the link
  assign link.req_valid = req_valid_r;
  assign link.req_abort = req_abort_r;
  assign link.req_station = stn_r;
  assign link.req_rate = cfg_r[`SLFS_F_RATE_LSB - `SLFS_F_RATE_LSB +: `SLFS_F_RATE_W];
  assign link.req_parity = cfg_r[3 +: `SLFS_F_PARITY_W];
  assign link.req_proto = cfg_r[5 +: `SLFS_F_PROTO_W];
endmodule // slfs_host

// ---- dv/slfs_link_checker.sv ----
// Concurrent checks on the frame level link between card end and inverter end
module slfs_link_checker (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic req_valid,
  input wire logic req_abort,
  input wire logic [7:0] req_station,
  input wire logic [2:0] req_rate,
  input wire logic [1:0] req_parity,
  input wire logic [1:0] req_proto,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_station
);
  // ==========================================================
  // Frame pulses, codes and response spacing
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_req_one_cycle: assert property (req_valid |=> !req_valid)
    else $error("request frame pulse longer than one cycle");
  a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid)
    else $error("response frame pulse longer than one cycle");
  a_rsp_station_match: assert property (rsp_valid |-> rsp_station == req_station)
    else $error("response from a station other than the one addressed");
  a_rsp_not_early: assert property (req_valid |=> !rsp_valid [*8])
    else $error("response before processing time elapsed");
  a_abort_alone: assert property (!(req_valid && req_abort))
    else $error("abort and complete frame in the same cycle");
  a_codes_reset: assert property ($rose(reset_n_i) |->
      req_rate == 3'h4 && req_parity == 2'h0 && req_proto == 2'h0)
    else $error("framing codes wrong after reset");
  a_station_reset: assert property ($rose(reset_n_i) |-> req_station == 8'h01)
    else $error("station address wrong after reset");
  a_codes_steady: assert property (req_valid |->
      $stable(req_rate) && $stable(req_parity) && $stable(req_proto))
    else $error("framing codes changed with a frame");
endmodule // slfs_link_checker

// ---- dv/serial_link_fault_supervisor_tb.sv ----
// Self-checking bench joining the card end and the inverter end over the link
module serial_link_fault_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Stimulus and observed signals
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel_d = 1'b0;
  logic psel_h = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_d, prdata_h, rdat;
  logic pready_d, pready_h, perr_d, perr_h, rerr, trip, irq_d, irq_h;
  int mismatches = 0;
  int tests_run = 0;
  int cnt = 0;
  int lat = 0;
  int exp_rsp = 0;

  // Clock
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  slfs_link_if link ();
  slfs_dev #(.TICK_CYCLES(10), .PROC_CYCLES(10)) slfs_dev_inst (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .paddr_i(paddr), .psel_i(psel_d), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata_d), .pready_o(pready_d),
    .pslverr_o(perr_d), .link(link.dev), .trip_o(trip), .irq_o(irq_d));
  slfs_host slfs_host_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .paddr_i(paddr),
    .psel_i(psel_h), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata_h), .pready_o(pready_h), .pslverr_o(perr_h), .link(link.host),
    .irq_o(irq_h));
  slfs_link_checker slfs_link_checker_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .req_valid(link.req_valid), .req_abort(link.req_abort), .req_station(link.req_station),
    .req_rate(link.req_rate), .req_parity(link.req_parity), .req_proto(link.req_proto),
    .rsp_valid(link.rsp_valid), .rsp_station(link.rsp_station));

  // Request to response latency, in edges
  always @(posedge mclk_i) begin
    cnt <= link.req_valid ? 0 : cnt + 1;
    if (link.rsp_valid) lat <= cnt + 1;
  end

  // ==========================================================
  // Tasks
  task automatic summarize();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer to the inverter end (h=0) or the card end (h=1)
  task automatic apb(input bit h, input bit w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel_d <= !h;
    psel_h <= h;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk_i);
      i++;
    end while ((h ? pready_h : pready_d) !== 1'b1 && i < 20);
    if (i >= 20) begin
      mismatches++;
      summarize();
    end
    rdat = h ? prdata_h : prdata_d;
    rerr = h ? perr_h : perr_d;
    psel_d <= 1'b0;
    psel_h <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic wr(input bit h, input logic [11:0] a, input logic [31:0] d);
    apb(h, 1'b1, a, d);
  endtask

  task automatic rd(input bit h, input logic [11:0] a, input logic [31:0] e, input string n);
    apb(h, 1'b0, a, 32'h0);
    chk(n, e, rdat);
  endtask

  function automatic logic sig(input int s);
    return s == 0 ? trip : (s == 1 ? irq_d : link.rsp_valid);
  endfunction

  // Event s must rise in [lo, hi) edges; lo == hi means it must not rise
  task automatic expect_at(input int s, input int lo, input int hi);
    int i;
    for (i = 0; i < hi; i++) begin
      @(posedge mclk_i);
      if (sig(s) === 1'b1) break;
    end
    chk("event_fired", lo < hi, i < hi);
    if (lo < hi) chk("event_early", 1, i >= lo);
    @(posedge mclk_i);
  endtask

  // Station 1, rate 4, no parity, protocol 0
  task automatic cfg(input logic [1:0] m, input logic [3:0] lm, input logic [1:0] bm,
                     input logic [31:0] tim);
    wr(1'b0, 12'h000, {7'h00, bm, lm, 6'h00, 3'h4, m, 8'h01});
    wr(1'b0, 12'h004, tim);
  endtask

  task automatic clr();
    wr(1'b0, 12'h008, 32'h1);
    wr(1'b0, 12'h010, 32'h7);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    int i;
    repeat (4) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(1'b0, 12'h000, 32'h0000_0c01, "set");
    rd(1'b0, 12'h004, 32'h0001_0014, "tim");
    rd(1'b0, 12'h00c, 32'h0000_0011, "stat");
    chk("pslverr_mapped", 0, rerr);
    rd(1'b1, 12'h004, 32'h0000_0004, "hcfg");
    rd(1'b1, 12'h000, 32'h0000_0100, "hctl");
    rd(1'b1, 12'h0fc, 32'h0, "h_unmapped");
    chk("h_pslverr", 1, rerr);
    rd(1'b0, 12'h0fc, 32'h0, "unmapped");
    chk("pslverr", 1, rerr);
    wr(1'b0, 12'h014, 32'h7);
    // No link command source: aborts ignored
    for (i = 0; i < 3; i++) begin
      cfg(2'h0, 4'(i * 4), 2'(i == 2), 32'h14);
      wr(1'b1, 12'h000, 32'h102);
      expect_at(0, 30, 30);
      rd(1'b0, 12'h010, 32'h0, "istat");
    end
    // Response after processing plus delay of 0 and 2 units
    for (i = 0; i < 3; i += 2) begin
      cfg(2'h0, 4'h8, 2'h0, 32'h14 | (i << 16));
      rd(1'b0, 12'h00c, 32'h1, "stat");
      wr(1'b1, 12'h000, 32'h101);
      exp_rsp++;
      expect_at(2, 0, 60);
      chk("latency", 11 + i * 10, lat);
    end
    // Mode 0 at once, mode 1 after the error timer
    cfg(2'h0, 4'h8, 2'h0, 32'h14);
    wr(1'b1, 12'h000, 32'h102);
    expect_at(0, 0, 5);
    rd(1'b0, 12'h010, 32'h3, "istat");
    chk("irq", 1, irq_d);
    clr();
    chk("trip", 0, trip);
    chk("irq", 0, irq_d);
    cfg(2'h1, 4'h8, 2'h0, 32'h2);
    wr(1'b1, 12'h000, 32'h102);
    expect_at(0, 150, 260);
    clr();
    // Mode 2 recovers on a good request, trips after the timer otherwise
    cfg(2'h2, 4'h8, 2'h0, 32'h2);
    wr(1'b1, 12'h000, 32'h102);
    rd(1'b0, 12'h00c, 32'h4, "stat");
    wr(1'b1, 12'h000, 32'h101);
    exp_rsp++;
    expect_at(2, 0, 60);
    rd(1'b0, 12'h00c, 32'h1, "stat");
    rd(1'b0, 12'h010, 32'h5, "istat");
    wr(1'b0, 12'h010, 32'h7);
    wr(1'b1, 12'h000, 32'h102);
    expect_at(0, 150, 260);
    clr();
    // Mode 3 keeps running
    cfg(2'h3, 4'h8, 2'h0, 32'h2);
    wr(1'b1, 12'h000, 32'h102);
    expect_at(0, 300, 300);
    rd(1'b0, 12'h00c, 32'h1, "stat");
    clr();
    // Only the run command from the link still makes errors count
    cfg(2'h0, 4'h2, 2'h0, 32'h14);
    wr(1'b1, 12'h000, 32'h102);
    expect_at(0, 0, 5);
    clr();
    // Wrong rate, parity or protocol code is a link error
    cfg(2'h0, 4'h8, 2'h0, 32'h14);
    for (i = 0; i < 3; i++) begin
      wr(1'b1, 12'h004, i == 0 ? 32'h3 : (i == 1 ? 32'hc : 32'h44));
      wr(1'b1, 12'h000, 32'h101);
      expect_at(0, 0, 5);
      clr();
    end
    wr(1'b1, 12'h004, 32'h4);
    // Data length and stop bits have no effect
    wr(1'b0, 12'h000, 32'h0041_9001);
    wr(1'b1, 12'h000, 32'h101);
    exp_rsp++;
    expect_at(2, 0, 60);
    chk("trip", 0, trip);
    // No-response time: idle in mode 0, fires within the time in mode 2
    cfg(2'h0, 4'h8, 2'h0, 32'h414);
    expect_at(1, 1300, 1300);
    cfg(2'h2, 4'h8, 2'h0, 32'h402);
    wr(1'b1, 12'h000, 32'h101);
    exp_rsp++;
    expect_at(1, 990, 1003);
    rd(1'b0, 12'h00c, 32'h4, "stat");
    wr(1'b1, 12'h000, 32'h101);
    exp_rsp++;
    expect_at(2, 0, 60);
    rd(1'b0, 12'h00c, 32'h1, "stat");
    rd(1'b0, 12'h010, 32'h5, "istat");
    wr(1'b0, 12'h004, 32'h14);
    clr();
    // Card end bookkeeping and interrupt
    rd(1'b1, 12'h008, {8'h00, 8'h01, 8'(exp_rsp), 8'h00}, "hstat");
    wr(1'b1, 12'h010, 32'h1);
    chk("host_irq", 1, irq_h);
    wr(1'b1, 12'h00c, 32'h3);
    chk("host_irq", 0, irq_h);
    summarize();
  end
endmodule // serial_link_fault_supervisor_tb
